//--- rtl/cpf_consts.svh
// Constants for the command packet framer: offsets, codes, timing
`ifndef CPF_CONSTS_SVH
`define CPF_CONSTS_SVH
`define CPF_POS_SUM8     8'h00
`define CPF_POS_CMD      8'h01
`define CPF_POS_WCNT     8'h02
`define CPF_POS_XCMD     8'h03
`define CPF_POS_SUM16_LO 8'h04
`define CPF_POS_SUM16_HI 8'h05
`define CPF_DEST_BIT     7
`define CPF_EXT_CODE     4'hF
`define CPF_NORM_MAX_CMD 4'hE
`define CPF_NORM_HDR     10'h002
`define CPF_EXT_HDR      10'h006
`define CPF_NORM_SUM_END 8'h0F
`define CPF_EXT_SUM_END  8'h05
`define CPF_EXT_MAX_WRDS 8'h7D
`define CPF_BAD_REPLY    8'hB8
`define CPF_SETTLE_NS    5000
`define CPF_CLK_NS       25
`define CPF_SETTLE_CYC   ((`CPF_SETTLE_NS + `CPF_CLK_NS - 1) / `CPF_CLK_NS)
`endif

//--- rtl/cpf_pkg.sv
// Types shared by the command packet framer
package cpf_pkg;
  typedef enum logic [1:0] {
    CPF_RECV,
    CPF_REPLY0,
    CPF_REPLY1
  } cpf_state_t;

  typedef struct packed {
    logic       remote;
    logic       extended;
    logic [7:0] cmd_num;
    logic [7:0] words;
    logic [2:0] aux;
  } cpf_info_t;

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] state;
  } cpf_port_t;
endpackage : cpf_pkg

//--- rtl/cpf_framer.sv
// Command packet framer: parse, checksum check, route, parameter masks
// Functional notes
// R01 - Normal packet: one command, 0-7 words
// R02 - Extended: three command words, 0-125 words
// R03 - Normal byte0 sums bytes 1-15
// R04 - Normal command number in bits 6-3
// R05 - Bits 2-0 give normal word count
// R06 - Bit 7 routes local or remote
// R07 - Bits 6-3 all ones mark extended
// R08 - Extended byte2 count, byte3 command
// R09 - Extended byte0 sums bytes 1-5 only
// R10 - Sixteen-bit payload sum at bytes 4-5
// R11 - Eight-bit sum adds carry back in
// R12 - Multi-byte fields least significant first
// R13 - Mask bit one updates parameter
// R14 - Mask bit zero keeps and reports
// R15 - Sixteen-bit analog mask picks channels
// R16 - Port mask updates lines, else reads
// R17 - Settle delay is value times 5us
// R18 - Field bit n maps to line n
// R19 - Remote bad checksum replies B8 B8
// R20 - Payload bytes are twice word count
// R21 - Normal command above 14 rejected
`timescale 1ns/1ps
`include "cpf_consts.svh"

module cpf_framer #(
  parameter int N_PARAM = 8,
  parameter int SETTLE_UNIT_CYC = `CPF_SETTLE_CYC
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   in_valid,
  input  wire logic [7:0]             in_data,
  output logic                        in_ready,
  output logic                        pay_valid,
  output logic [7:0]                  pay_byte,
  output logic                        pkt_local,
  output logic                        pkt_remote,
  output logic                        pkt_bad,
  output cpf_pkg::cpf_info_t          pkt_info,
  output logic                        reply_valid,
  output logic [7:0]                  reply_byte,
  input  wire logic                   reply_ready,
  input  wire logic                   param_write,
  input  wire logic [N_PARAM-1:0]     param_update_mask,
  input  wire logic [N_PARAM*8-1:0]   param_new,
  output logic [N_PARAM*8-1:0]        param_value,
  input  wire logic [15:0]            analog_channel_select,
  input  wire logic [7:0]             extra_settle_delay,
  input  wire logic                   sample_req,
  output logic [15:0]                 acq_channels,
  output logic                        sample_go,
  input  wire logic                   port_write,
  input  wire logic [7:0]             port_line_update_mask,
  input  wire cpf_pkg::cpf_port_t     port_new,
  input  wire logic [7:0]             port_pins,
  output cpf_pkg::cpf_port_t          port_drive,
  output cpf_pkg::cpf_port_t          port_readback
);

  // Ones' complement byte add: carry folds back into the sum
  function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    add8 = s[7:0] + {7'h00, s[8]}; // [R11]
  endfunction : add8

  cpf_pkg::cpf_state_t state_reg, state_next;
  cpf_pkg::cpf_info_t  info_reg, info_next;
  logic [7:0]  idx_reg, idx_next, s8_reg, s8_next, e8_reg, e8_next;
  logic [9:0]  total_reg, total_next;
  logic [15:0] s16_reg, s16_next, e16_reg, e16_next;
  logic        long_reg, long_next, pv_reg, pv_next;
  logic [7:0]  pb_reg, pb_next;
  logic        loc_reg, loc_next, rem_reg, rem_next, bad_reg, bad_next;

  // Packet parser next-state
  always_comb
  begin
    logic [7:0]  b, s8;
    logic [15:0] s16;
    logic [9:0]  tot;
    logic        ext, last, ok;
    b = in_data;
    s8 = s8_reg;
    s16 = s16_reg;
    tot = total_reg;
    ext = info_reg.extended;
    last = 1'b0;
    ok = 1'b0;
    state_next = state_reg;
    info_next = info_reg;
    idx_next = idx_reg;
    total_next = total_reg;
    s8_next = s8_reg;
    e8_next = e8_reg;
    s16_next = s16_reg;
    e16_next = e16_reg;
    long_next = long_reg;
    pv_next = 1'b0;
    pb_next = pb_reg;
    loc_next = 1'b0;
    rem_next = 1'b0;
    bad_next = 1'b0;
    unique case (state_reg)
      cpf_pkg::CPF_RECV:
      begin
        if (in_valid)
        begin
          if (idx_reg == `CPF_POS_SUM8)
          begin
            e8_next = b;
            s8 = 8'h00;
            s16 = 16'h0000;
            long_next = 1'b0;
          end
          else if (idx_reg == `CPF_POS_CMD)
          begin
            ext = (b[6:3] == `CPF_EXT_CODE); // [R07]
            info_next.remote = b[`CPF_DEST_BIT]; // [R06]
            info_next.extended = ext;
            info_next.aux = b[2:0];
            info_next.cmd_num = {4'h0, b[6:3]}; // [R04] [R21]
            info_next.words = {5'h00, b[2:0]}; // [R05] [R01]
            // Word count times two gives payload bytes
            tot = ext ? `CPF_EXT_HDR : `CPF_NORM_HDR + {6'h00, b[2:0], 1'b0}; // [R20]
            s8 = add8(s8_reg, b);
          end
          else
          begin
            // Header sum span differs by packet type
            if (ext ? idx_reg <= `CPF_EXT_SUM_END : idx_reg <= `CPF_NORM_SUM_END)
              s8 = add8(s8_reg, b); // [R03] [R09]
            if (ext && idx_reg == `CPF_POS_WCNT)
            begin
              info_next.words = b; // [R08]
              long_next = (b > `CPF_EXT_MAX_WRDS); // [R02]
              tot = `CPF_EXT_HDR + {1'b0, b, 1'b0}; // [R20]
            end
            if (ext && idx_reg == `CPF_POS_XCMD)
              info_next.cmd_num = b; // [R08]
            if (ext && idx_reg == `CPF_POS_SUM16_LO)
              e16_next[7:0] = b; // [R10] [R12]
            if (ext && idx_reg == `CPF_POS_SUM16_HI)
              e16_next[15:8] = b; // [R10]
            if (ext && idx_reg > `CPF_POS_SUM16_HI)
              s16 = s16_reg + {8'h00, b}; // [R10]
            // Payload passes on as it arrives
            if (ext ? idx_reg > `CPF_POS_SUM16_HI : idx_reg > `CPF_POS_CMD)
            begin
              pv_next = 1'b1;
              pb_next = b;
            end
          end
          last = (idx_reg != `CPF_POS_SUM8) && ({2'b00, idx_reg} + 10'h001 == tot);
          if (long_next)
            last = (idx_reg == `CPF_POS_WCNT); // Oversize count ends the packet early
          s8_next = s8;
          s16_next = s16;
          total_next = tot;
          if (last)
          begin
            ok = (s8 == e8_reg) && !long_next;
            if (ext && !long_next)
              ok = ok && (s16 == e16_next);
            idx_next = 8'h00;
            loc_next = ok && !info_next.remote; // [R06]
            rem_next = ok && info_next.remote; // [R06]
            bad_next = !ok;
            if (!ok && info_next.remote)
              state_next = cpf_pkg::CPF_REPLY0; // [R19]
          end
          else
            idx_next = idx_reg + 8'h01;
        end
      end
      cpf_pkg::CPF_REPLY0:
      begin
        if (reply_ready)
          state_next = cpf_pkg::CPF_REPLY1; // [R19]
      end
      cpf_pkg::CPF_REPLY1:
      begin
        if (reply_ready)
          state_next = cpf_pkg::CPF_RECV;
      end
      default:
        state_next = cpf_pkg::CPF_RECV;
    endcase
  end

  // Parser registers
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_reg <= cpf_pkg::CPF_RECV;
      info_reg  <= '0;
      idx_reg   <= 8'h00;
      total_reg <= 10'h000;
      s8_reg    <= 8'h00;
      e8_reg    <= 8'h00;
      s16_reg   <= 16'h0000;
      e16_reg   <= 16'h0000;
      long_reg  <= 1'b0;
      pv_reg    <= 1'b0;
      pb_reg    <= 8'h00;
      loc_reg   <= 1'b0;
      rem_reg   <= 1'b0;
      bad_reg   <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      info_reg  <= info_next;
      idx_reg   <= idx_next;
      total_reg <= total_next;
      s8_reg    <= s8_next;
      e8_reg    <= e8_next;
      s16_reg   <= s16_next;
      e16_reg   <= e16_next;
      long_reg  <= long_next;
      pv_reg    <= pv_next;
      pb_reg    <= pb_next;
      loc_reg   <= loc_next;
      rem_reg   <= rem_next;
      bad_reg   <= bad_next;
    end
  end

  // Input stalls only while the error reply is out
  assign in_ready    = (state_reg == cpf_pkg::CPF_RECV);
  assign reply_valid = (state_reg != cpf_pkg::CPF_RECV); // [R19]
  assign reply_byte  = reply_valid ? `CPF_BAD_REPLY : 8'h00;
  assign pay_valid   = pv_reg;
  assign pay_byte    = pb_reg;
  assign pkt_local   = loc_reg;
  assign pkt_remote  = rem_reg;
  assign pkt_bad     = bad_reg;
  assign pkt_info    = info_reg;

  logic [N_PARAM*8-1:0] par_reg, par_next;
  logic [15:0]          acq_reg, acq_next;
  cpf_pkg::cpf_port_t   drv_reg, drv_next, rb_reg, rb_next;

  // Masked parameter, channel and port updates
  always_comb
  begin
    par_next = par_reg;
    drv_next = drv_reg;
    acq_next = analog_channel_select; // [R15]
    if (param_write)
      for (int i = 0; i < N_PARAM; i++)
        if (param_update_mask[i])
          par_next[i*8 +: 8] = param_new[i*8 +: 8]; // [R13] [R14]
    // Bit n of each field acts on line n only
    if (port_write)
      for (int n = 0; n < 8; n++)
        if (port_line_update_mask[n])
        begin
          drv_next.dir[n]   = port_new.dir[n]; // [R16] [R18]
          drv_next.state[n] = port_new.state[n];
        end
    // Readback shows current direction and pin levels
    rb_next.dir   = drv_next.dir;
    rb_next.state = port_pins; // [R16]
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      par_reg <= '0;
      acq_reg <= 16'h0000;
      drv_reg <= '0;
      rb_reg  <= '0;
    end
    else
    begin
      par_reg <= par_next;
      acq_reg <= acq_next;
      drv_reg <= drv_next;
      rb_reg  <= rb_next;
    end
  end

  assign param_value   = par_reg; // [R14]
  assign acq_channels  = acq_reg; // [R15]
  assign port_drive    = drv_reg;
  assign port_readback = rb_reg;

  logic [17:0] st_reg, st_next;
  logic        sb_reg, sb_next, go_reg, go_next;

  // Settling wait: one request waits delay units, then fires.
  // A request while busy is dropped so the count stays exact.
  always_comb
  begin
    st_next = st_reg;
    sb_next = sb_reg;
    go_next = 1'b0;
    if (!sb_reg)
    begin
      if (sample_req)
      begin
        st_next = 18'(extra_settle_delay * SETTLE_UNIT_CYC); // [R17]
        sb_next = 1'b1;
      end
    end
    else if (st_reg == 18'h0_0000)
    begin
      go_next = 1'b1;
      sb_next = 1'b0;
    end
    else
      st_next = st_reg - 18'h0_0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      st_reg <= 18'h0_0000;
      sb_reg <= 1'b0;
      go_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      sb_reg <= sb_next;
      go_reg <= go_next;
    end
  end

  assign sample_go = go_reg;

endmodule : cpf_framer

//--- sim/cpf_framer_asserts.sv
// Port checks for the command packet framer
`timescale 1ns/1ps
module cpf_framer_asserts (
  input wire logic               core_clk,
  input wire logic               reset,
  input wire logic               in_ready,
  input wire logic               pkt_local,
  input wire logic               pkt_remote,
  input wire logic               pkt_bad,
  input wire cpf_pkg::cpf_info_t pkt_info,
  input wire logic               reply_valid,
  input wire logic [7:0]         reply_byte,
  input wire logic               reply_ready,
  input wire logic [7:0]         extra_settle_delay,
  input wire logic               sample_req,
  input wire logic               sample_go
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Error reply: fixed code, held until taken, input closed meanwhile
  a_reply_code: assert property (reply_valid |-> reply_byte == 8'hB8)
    else $error("reply byte is not the error code");
  a_reply_holds: assert property (reply_valid && !reply_ready |=> reply_valid)
    else $error("reply byte dropped before taken");
  a_reply_blocks: assert property (reply_valid |-> !in_ready)
    else $error("input open during reply");
  a_bad_reply: assert property (pkt_bad |-> reply_valid == pkt_info.remote)
    else $error("reply does not follow remote bad packet");
  a_reply_length: assert property (pkt_bad && pkt_info.remote && reply_ready ##1 reply_ready
    |=> !reply_valid && in_ready)
    else $error("reply is not two bytes");
  // One outcome per packet, routed by the destination bit
  a_one_outcome: assert property ($onehot0({pkt_local, pkt_remote, pkt_bad}))
    else $error("more than one packet outcome");
  a_route_bit: assert property (pkt_local || pkt_remote |-> pkt_info.remote == pkt_remote)
    else $error("packet routed against its destination bit");
  a_ext_limit: assert property ((pkt_local || pkt_remote) && pkt_info.extended
    |-> pkt_info.words <= 8'h7D)
    else $error("long packet accepted with too many words");
  a_norm_fields: assert property ((pkt_local || pkt_remote) && !pkt_info.extended
    |-> pkt_info.cmd_num <= 8'h0E && pkt_info.words <= 8'h07)
    else $error("short packet fields out of range");
  a_settle_zero: assert property (sample_req && extra_settle_delay == 8'h00
    |-> ##2 sample_go)
    else $error("sample start late with no extra delay");
  cover property (pkt_local);
  cover property (pkt_remote && pkt_info.extended);
  cover property (pkt_bad ##1 reply_valid);
endmodule : cpf_framer_asserts

bind cpf_framer cpf_framer_asserts u_chk (.core_clk(core_clk), .reset(reset),
  .in_ready(in_ready), .pkt_local(pkt_local), .pkt_remote(pkt_remote), .pkt_bad(pkt_bad),
  .pkt_info(pkt_info), .reply_valid(reply_valid), .reply_byte(reply_byte),
  .reply_ready(reply_ready), .extra_settle_delay(extra_settle_delay),
  .sample_req(sample_req), .sample_go(sample_go));

//--- sim/cpf_host_model.sv
// Host side: sends packet bytes, takes reply bytes
`timescale 1ns/1ps
module cpf_host_model (
  input wire logic  core_clk,
  input wire logic  in_ready,
  input wire logic  slow,
  output logic      in_valid,
  output logic [7:0] in_data,
  output logic      reply_ready
);
  initial
  begin
    in_valid = 1'b0;
    in_data = 8'h00;
    reply_ready = 1'b1;
  end
  // A slow host drops reply_ready every other cycle so each byte must stand
  always @(posedge core_clk)
    #1 reply_ready <= slow ? ~reply_ready : 1'b1;
  // Bytes stay put until taken; a released line shows no stale byte
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i])
    begin
      in_valid = 1'b1;
      in_data = b[i];
      do @(posedge core_clk); while (!in_ready);
      #1;
    end
    in_valid = 1'b0;
    in_data = ~in_data;
  endtask : send
endmodule : cpf_host_model

//--- sim/tb_command_packet_framer.sv
// Self-checking bench for the command packet framer
`timescale 1ns/1ps
module tb_command_packet_framer;
  typedef logic [7:0] cpf_bytes_t[$];
  logic core_clk = 1'b0, reset = 1'b1, slow = 1'b0;
  logic in_valid, in_ready, reply_ready, pay_valid, pkt_local, pkt_remote, pkt_bad;
  logic reply_valid, sample_go, param_write = 1'b0, port_write = 1'b0, sample_req = 1'b0;
  logic [7:0] in_data, pay_byte, reply_byte, param_update_mask = 8'h00;
  logic [7:0] extra_settle_delay = 8'h00, port_line_update_mask = 8'h00, port_pins = 8'h00;
  logic [15:0] analog_channel_select = 16'h0000, acq_channels;
  logic [63:0] param_new = 64'h0, param_value, ref_p = 64'h0;
  cpf_pkg::cpf_info_t pkt_info, info;
  cpf_pkg::cpf_port_t port_new = 16'h0000, port_drive, port_readback, ref_d = 16'h0000;
  logic [2:0] seen;
  cpf_bytes_t pay_q;
  int seed = 44, checks = 0, failures = 0, n_rep = 0, k;

  always #12.5 core_clk = ~core_clk;

  cpf_framer #(.SETTLE_UNIT_CYC(2)) dut (.core_clk, .reset, .in_valid, .in_data, .in_ready,
    .pay_valid, .pay_byte, .pkt_local, .pkt_remote, .pkt_bad, .pkt_info, .reply_valid,
    .reply_byte, .reply_ready, .param_write, .param_update_mask, .param_new, .param_value,
    .analog_channel_select, .extra_settle_delay, .sample_req, .acq_channels, .sample_go,
    .port_write, .port_line_update_mask, .port_new, .port_pins, .port_drive, .port_readback);
  cpf_host_model host (.core_clk, .in_ready, .slow, .in_valid, .in_data, .reply_ready);

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  // Carry-folding byte sum over bytes 1..hi
  function automatic logic [7:0] sum8(input cpf_bytes_t b, input int hi);
    logic [15:0] a;
    a = 16'h0000;
    for (int i = 1; i <= hi; i++)
      a = a + b[i];
    a = a[15:8] + a[7:0];
    a = a[15:8] + a[7:0];
    return a[7:0];
  endfunction : sum8

  // Builds a packet with random payload; bad bit 0 spoils the header sum, bit 1 the payload sum
  function automatic cpf_bytes_t mk(input logic dst, input logic ext, input logic [3:0] cmd,
                                    input logic [7:0] w, input logic [1:0] bad);
    cpf_bytes_t b;
    logic [15:0] s;
    s = 16'h0000;
    for (int i = 0; i < (ext ? 6 : 2) + 2 * w; i++)
      b.push_back(8'($random(seed)));
    b[1] = ext ? {dst, 4'hF, cmd[2:0]} : {dst, cmd, w[2:0]};
    if (ext)
    begin
      b[2] = w;
      for (int i = 6; i < b.size(); i++)
        s = s + b[i];
      b[4] = s[7:0] ^ {7'h00, bad[1]};
      b[5] = s[15:8];
    end
    b[0] = sum8(b, ext ? 5 : b.size() - 1) ^ {7'h00, bad[0]};
    return b;
  endfunction : mk

  // Watches outcome pulses, payload bytes and taken reply bytes
  always @(posedge core_clk)
  begin
    if (pay_valid) pay_q.push_back(pay_byte);
    if (pkt_local | pkt_remote | pkt_bad)
    begin
      seen = {pkt_local, pkt_remote, pkt_bad};
      info = pkt_info;
    end
    if (reply_valid && reply_ready) n_rep++;
    if (reply_valid && reply_ready) check(reply_byte, 8'hB8);
  end

  task automatic run_pkt(input logic dst, input logic ext, input logic [3:0] cmd,
                         input logic [7:0] w, input logic [1:0] bad);
    cpf_bytes_t b;
    b = mk(dst, ext, cmd, w, bad);
    if (w > 8'h7D) b = b[0:2];
    seen = 3'b000;
    pay_q = {};
    n_rep = 0;
    host.send(b);
    for (k = 0; k < 3 || (!in_ready && k < 40); k++) @(posedge core_clk);
    #1;
    check(seen, bad ? 3'b001 : {~dst, dst, 1'b0});
    if (!bad)
    begin
      check({info[20:3]}, {dst, ext, ext ? b[3] : {4'h0, cmd}, w});
      if (ext) check(info.aux, cmd[2:0]);
      check(pay_q.size(), 2 * w);
      foreach (pay_q[i]) check(pay_q[i], b[(ext ? 6 : 2) + i]);
    end
    check(n_rep, bad && dst ? 2 : 0);
  endtask : run_pkt

  // Main sequence: packets, faults, masks, settle delay
  initial
  begin
    logic [7:0] w;
    repeat (2) @(posedge core_clk);
    #1 reset = 1'b0;
    check(param_value, 64'h0);
    check({acq_channels, port_drive, port_readback}, 64'h0);
    for (int i = 0; i < 24; i++)
    begin
      w = i[0] ? (i == 1 ? 8'h7D : i == 3 ? 8'h00 : 8'($unsigned($random(seed)) % 126))
               : (i == 0 ? 8'h00 : i == 2 ? 8'h07 : 8'($random(seed) & 7));
      run_pkt(1'($random(seed)), i[0], i == 2 ? 4'hE : 4'($unsigned($random(seed)) % 15), w, 2'b00);
    end
    slow = 1'b1;
    run_pkt(1'b1, 1'b0, 4'h5, 8'h03, 1'b1);
    run_pkt(1'b0, 1'b1, 4'h2, 8'h04, 1'b1);
    slow = 1'b0;
    run_pkt(1'b1, 1'b1, 4'h1, 8'h0A, 1'b1);
    run_pkt(1'b1, 1'b1, 4'h3, 8'h05, 2'b10);
    run_pkt(1'b0, 1'b1, 4'h0, 8'h7E, 1'b1);
    for (int i = 0; i < 6; i++)
    begin
      param_write = 1'b1;
      port_write = 1'b1;
      param_update_mask = i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($random(seed));
      port_line_update_mask = i == 0 ? 8'h00 : i == 1 ? 8'hFF : 8'($random(seed));
      param_new = {$random(seed), $random(seed)};
      port_new = 16'($random(seed));
      port_pins = 8'($random(seed));
      analog_channel_select = 16'($random(seed));
      for (int j = 0; j < 8; j++)
        if (param_update_mask[j]) ref_p[j*8 +: 8] = param_new[j*8 +: 8];
      ref_d = (port_new & {2{port_line_update_mask}}) | (ref_d & ~{2{port_line_update_mask}});
      @(posedge core_clk);
      #1;
      param_write = 1'b0;
      port_write = 1'b0;
      check(param_value, ref_p);
      check(port_drive, ref_d);
      check(port_readback, {ref_d.dir, port_pins});
      check(acq_channels, analog_channel_select);
    end
    for (int d = 0; d < 6; d += 3)
    begin
      extra_settle_delay = d[7:0];
      sample_req = 1'b1;
      @(posedge core_clk);
      #1 sample_req = 1'b0;
      k = 0;
      do @(posedge core_clk); while (!sample_go && ++k < 50);
      check(k + 1, d * 2 + 2);
      #1;
    end
    print_verdict();
  end

  // Cuts a hang short well beyond the expected run length
  initial
  begin
    #200000;
    failures++;
    print_verdict();
  end
endmodule : tb_command_packet_framer
